//--- cicg_defines.svh
`ifndef CICG_DEFINES_SVH
`define CICG_DEFINES_SVH

// Datapath widths
`define CICG_PROD_W      32
`define CICG_IN_W        15
`define CICG_ACC_W       40
`define CICG_OUT_W       32
`define CICG_NSTAGES     5

// Integrator accumulator widths, first stage to last
`define CICG_INT_W0      40
`define CICG_INT_W1      36
`define CICG_INT_W2      32
`define CICG_INT_W3      32
`define CICG_INT_W4      32

// Configuration word field positions
`define CICG_BYPASS_BIT  6
`define CICG_DEC_LSB     7
`define CICG_DEC_MSB     12
`define CICG_SHIFT_LSB   13
`define CICG_SHIFT_MSB   16
`define CICG_SYNC_EN_BIT 19

// Shift saturation limit, 6 dB per step
`define CICG_SHIFT_MAX   4'hf

// Reset values
`define CICG_DEC_RST     6'h00
`define CICG_GAIN_RST    3'h0

`endif

//--- cicg_pkg.sv
`include "cicg_defines.svh"

package cicg_pkg;

    // Decoded configuration fields
    typedef struct packed {
        logic       ext_sync_en;
        logic [3:0] shift_word;
        logic [5:0] dec_preload;
        logic       bypass;
    } cicg_cfg_t;

    // Sample handed to the halfband chain
    typedef struct packed {
        logic [`CICG_OUT_W-1:0] data;
    } cicg_sample_t;

endpackage : cicg_pkg

//--- cicg_sym_round.sv
`timescale 1ns/1ps
`default_nettype none

`include "cicg_defines.svh"

module cicg_sym_round #(
    parameter int PROD_W = `CICG_PROD_W,
    parameter int OUT_W  = `CICG_IN_W
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [PROD_W-1:0] prod,
    input  wire logic              prod_valid,
    output var  logic [OUT_W-1:0]  rnd_data,
    output var  logic              rnd_valid
);

    localparam int DROP = PROD_W - OUT_W;

    logic [PROD_W:0] half;
    logic [PROD_W:0] sum;
    logic            ovf;

    // Round half away from zero so positive and negative sides match
    always_comb begin
        half = (PROD_W+1)'(1) << (DROP - 1);
        if (prod[PROD_W-1]) begin
            sum = {prod[PROD_W-1], prod} + half - (PROD_W+1)'(1);
        end else begin
            sum = {prod[PROD_W-1], prod} + half;
        end
        ovf = (sum[PROD_W] != sum[PROD_W-1]);
    end

    // Registered result; overflow clamps instead of flipping sign
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rnd_data  <= '0;
            rnd_valid <= 1'b0;
        end else begin
            rnd_valid <= prod_valid;
            if (prod_valid) begin
                if (ovf) begin
                    rnd_data <= {sum[PROD_W], {(OUT_W-1){~sum[PROD_W]}}};
                end else begin
                    rnd_data <= sum[PROD_W-1 -: OUT_W];
                end
            end
        end
    end

endmodule : cicg_sym_round

`default_nettype wire

//--- cicg_decimator.sv
`timescale 1ns/1ps
`default_nettype none

`include "cicg_defines.svh"

module cicg_decimator #(
    parameter int NSTAGES = `CICG_NSTAGES
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic [31:0]                   cfg_word,
    input  wire logic [`CICG_PROD_W-1:0]       mix_prod,
    input  wire logic                          sample_valid_n,
    input  wire logic [2:0]                    pin_gain_offset,
    input  wire logic                          multi_chip_sync_pulse,
    output var  cicg_pkg::cicg_sample_t        out_sample,
    output var  logic                          out_strobe,
    output var  logic [5:0]                    dec_count
);

    import cicg_pkg::*;

    localparam int AW = `CICG_ACC_W;
    localparam int IW = `CICG_IN_W;
    localparam int OW = `CICG_OUT_W;

    // Accumulator width of a given integrator stage
    function automatic int stage_width(input int k);
        case (k)
            0:       return `CICG_INT_W0;
            1:       return `CICG_INT_W1;
            2:       return `CICG_INT_W2;
            3:       return `CICG_INT_W3;
            default: return `CICG_INT_W4;
        endcase
    endfunction : stage_width

    // Keep the top w bits of a 40-bit word, clearing the pruned LSBs
    function automatic logic [AW-1:0] prune(input logic [AW-1:0] x, input int w);
        logic [AW-1:0] m;
        m = ~((AW'(1) << (AW - w)) - AW'(1));
        return x & m;
    endfunction : prune

    // Split the configuration word into its fields
    function automatic cicg_cfg_t decode_cfg(input logic [31:0] w);
        cicg_cfg_t c;
        c.bypass      = w[`CICG_BYPASS_BIT];
        c.dec_preload = w[`CICG_DEC_MSB:`CICG_DEC_LSB];
        c.shift_word  = w[`CICG_SHIFT_MSB:`CICG_SHIFT_LSB];
        c.ext_sync_en = w[`CICG_SYNC_EN_BIT];
        return c;
    endfunction : decode_cfg

    cicg_cfg_t          cfg;
    logic               in_valid;
    logic [IW-1:0]      rnd_data;
    logic               rnd_valid;
    logic [2:0]         gain_meta_r;
    logic [2:0]         gain_sync_r;
    logic [2:0]         gain_pipe_r;
    logic               sync_meta_r;
    logic               sync_sync_r;
    logic               sync_last_r;
    logic               sync_load;
    logic [4:0]         shift_sum;
    logic [3:0]         shift_amt;
    logic [AW-1:0]      sh_data_r;
    logic               sh_valid_r;
    logic [5:0]         dec_count_r;
    logic               dump_r;
    logic [AW-1:0]      integ_r [NSTAGES];
    logic [AW-1:0]      integ_src [NSTAGES];
    logic [OW-1:0]      comb_dly_r [NSTAGES];
    logic [OW-1:0]      comb_val [NSTAGES+1];

    assign cfg      = decode_cfg(cfg_word);
    assign in_valid = ~sample_valid_n;

    // Mixer products enter through the symmetric rounder
    cicg_sym_round #(
        .PROD_W (`CICG_PROD_W),
        .OUT_W  (IW)
    ) u_round (
        .mclk       (mclk),
        .rst        (rst),
        .prod       (mix_prod),
        .prod_valid (in_valid),
        .rnd_data   (rnd_data),
        .rnd_valid  (rnd_valid)
    );

    // Gain pins are asynchronous, so two flops before any use
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gain_meta_r <= `CICG_GAIN_RST;
            gain_sync_r <= `CICG_GAIN_RST;
        end else begin
            gain_meta_r <= pin_gain_offset;
            gain_sync_r <= gain_meta_r;
        end
    end

    // Gain is captured with its sample and rides the rounder's delay
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gain_pipe_r <= `CICG_GAIN_RST;
        end else if (in_valid) begin
            gain_pipe_r <= gain_sync_r;
        end
    end

    // Sync pin: two flops, then an edge detector on the clean copy
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_meta_r <= 1'b0;
            sync_sync_r <= 1'b0;
            sync_last_r <= 1'b0;
        end else begin
            sync_meta_r <= multi_chip_sync_pulse;
            sync_sync_r <= sync_meta_r;
            sync_last_r <= sync_sync_r;
        end
    end

    assign sync_load = cfg.ext_sync_en & sync_sync_r & ~sync_last_r;

    // Pin code counts one extra 6 dB step per unit; sum clamps rather than wraps
    always_comb begin
        shift_sum = {1'b0, cfg.shift_word} + {2'b00, gain_pipe_r};
        if (shift_sum > {1'b0, `CICG_SHIFT_MAX}) begin
            shift_amt = `CICG_SHIFT_MAX;
        end else begin
            shift_amt = shift_sum[3:0];
        end
    end

    // Barrel shifter: each shift step is 6 dB of gain
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sh_data_r  <= '0;
            sh_valid_r <= 1'b0;
        end else begin
            sh_valid_r <= rnd_valid & ~cfg.bypass;
            if (rnd_valid) begin
                sh_data_r <= {{(AW-IW){rnd_data[IW-1]}}, rnd_data} << shift_amt;
            end
        end
    end

    // Decimation counter; the sync reload wins over normal counting
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dec_count_r <= `CICG_DEC_RST;
            dump_r      <= 1'b0;
        end else begin
            dump_r <= 1'b0;
            if (sync_load) begin
                dec_count_r <= cfg.dec_preload;
            end else if (sh_valid_r) begin
                if (dec_count_r == 6'h00) begin
                    dec_count_r <= cfg.dec_preload;
                    dump_r      <= 1'b1;
                end else begin
                    dec_count_r <= dec_count_r - 6'h01;
                end
            end
        end
    end

    assign dec_count = dec_count_r;

    // Integrator cascade; pruned LSBs stay zero so each stage acts at its width
    genvar k;
    generate
        for (k = 0; k < NSTAGES; k++) begin : g_integ
            // Source picked at elaboration, so no stage ever indexes below zero
            if (k == 0) begin : g_first
                assign integ_src[k] = sh_data_r;
            end else begin : g_next
                assign integ_src[k] = integ_r[k-1];
            end
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    integ_r[k] <= '0;
                end else if (sh_valid_r) begin
                    integ_r[k] <= prune(integ_r[k] + integ_src[k], stage_width(k));
                end
            end
        end
    endgenerate

    // Comb cascade input is the top of the last integrator
    assign comb_val[0] = integ_r[NSTAGES-1][AW-1 -: OW];

    // Combs wrap modulo 2^32, cancelling any integrator overflow
    generate
        for (k = 0; k < NSTAGES; k++) begin : g_comb
            assign comb_val[k+1] = comb_val[k] - comb_dly_r[k];
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    comb_dly_r[k] <= '0;
                end else if (dump_r) begin
                    comb_dly_r[k] <= comb_val[k];
                end
            end
        end
    endgenerate

    // Output: filter result on a dump, or the raw rounded sample in bypass
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_sample <= '0;
            out_strobe <= 1'b0;
        end else begin
            if (cfg.bypass) begin
                out_strobe <= rnd_valid;
                if (rnd_valid) begin
                    out_sample.data <= {rnd_data, {(OW-IW){1'b0}}};
                end
            end else begin
                out_strobe <= dump_r;
                if (dump_r) begin
                    out_sample.data <= comb_val[NSTAGES];
                end
            end
        end
    end

endmodule : cicg_decimator

`default_nettype wire

//--- cicg_decimator_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cicg_decimator_assertions #(
    parameter int NSTAGES = 5
) (
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire logic [31:0]            cfg_word,
    input wire logic [31:0]            mix_prod,
    input wire logic                   sample_valid_n,
    input wire logic [2:0]             pin_gain_offset,
    input wire logic                   multi_chip_sync_pulse,
    input wire cicg_pkg::cicg_sample_t out_sample,
    input wire logic                   out_strobe,
    input wire logic [5:0]             dec_count
);
    import cicg_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // A sample taken while the filter is bypassed
    sequence byp_take;
        cfg_word[6] && !sample_valid_n;
    endsequence
    // Enabled sync edge seen at the pin; the pin passes two flops first
    sequence sync_arm;
        cfg_word[19] && $rose(multi_chip_sync_pulse);
    endsequence
    // Clean low part means the rounded value is exactly the top 15 bits
    property byp_data;
        logic [14:0] d;
        (byp_take ##0 (mix_prod[16:0] == 17'h0), d = mix_prod[31:17])
            |-> ##2 (out_sample.data == {d, 17'h0});
    endproperty
    chk_byp_strobe: assert property (byp_take |-> ##2 out_strobe)
        else $error("bypass sample gave no strobe two cycles later");
    chk_byp_data: assert property (byp_data)
        else $error("bypass output differs from the rounded sample");
    chk_sync_reload: assert property (sync_arm |-> ##[2:4] (dec_count == cfg_word[12:7]))
        else $error("enabled sync did not reload the counter");
    chk_sync_off: assert property ((!cfg_word[19] && sample_valid_n) [*5] |-> $stable(dec_count))
        else $error("counter moved without sample or enabled sync");
    chk_strobe_cause: assert property (out_strobe |-> (!$past(sample_valid_n, 2) || !$past(sample_valid_n, 4)))
        else $error("strobe without a sample two or four cycles before");
    chk_idle_quiet: assert property (sample_valid_n [*5] |-> !out_strobe)
        else $error("strobe after a long idle stretch");
    chk_out_hold: assert property (!$stable(out_sample) |-> out_strobe)
        else $error("output sample changed without a strobe");
    chk_reset_quiet: assert property ($fell(rst) |-> (out_sample.data == 32'h0 && !out_strobe && dec_count == 6'h0))
        else $error("outputs not cleared by reset");
endmodule : cicg_decimator_assertions
bind cicg_decimator cicg_decimator_assertions #(.NSTAGES(NSTAGES)) cicg_decimator_assertions_i (
    .mclk(mclk), .rst(rst), .cfg_word(cfg_word), .mix_prod(mix_prod),
    .sample_valid_n(sample_valid_n), .pin_gain_offset(pin_gain_offset),
    .multi_chip_sync_pulse(multi_chip_sync_pulse), .out_sample(out_sample),
    .out_strobe(out_strobe), .dec_count(dec_count));
`default_nettype wire

//--- cicg_mixer_model.sv
`timescale 1ns/1ps
`default_nettype none
module cicg_mixer_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [14:0] val,
    input  wire logic [9:0]  num,
    input  wire logic        go,
    output var  logic [31:0] mix_prod,
    output var  logic        sample_valid_n,
    output var  logic        busy
);
    logic [10:0] left_r;
    assign busy = (left_r != 11'h0);
    // One sample every other cycle, so bypass mode always sees a gap; idle data flips
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            left_r <= 11'h0;
            sample_valid_n <= 1'b1;
            mix_prod <= 32'h0;
        end else if (go) begin
            left_r <= {num, 1'b0};
        end else if (busy && !left_r[0]) begin
            left_r <= left_r - 11'h1;
            sample_valid_n <= 1'b0;
            mix_prod <= {val, 17'h0};
        end else begin
            left_r <= busy ? left_r - 11'h1 : left_r;
            sample_valid_n <= 1'b1;
            mix_prod <= ~mix_prod;
        end
    end
endmodule : cicg_mixer_model
`default_nettype wire

//--- cicg_decimator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cicg_decimator_tb;
    import cicg_pkg::*;
    typedef struct packed {
        cicg_cfg_t   cfg;
        logic [2:0]  gain;
        logic [14:0] v;
        logic [31:0] exp;
    } cicg_row_t;
    logic         mclk = 1'b0;
    logic         rst = 1'b1;
    logic [31:0]  cfg_word = 32'h0;
    logic [2:0]   pin_gain_offset = 3'h0;
    logic         multi_chip_sync_pulse = 1'b0;
    logic [14:0]  val = 15'h0;
    logic [9:0]   num = 10'h0;
    logic         go = 1'b0;
    logic [31:0]  mix_prod;
    logic         sample_valid_n;
    logic         busy;
    logic         out_strobe;
    logic [5:0]   dec_count;
    cicg_sample_t out_sample;
    int           miscompares = 0;
    int           n_checks = 0;
    int           n_strobe = 0;
    // Steady DC input: outside bypass (row 0) output is the shifted sample times ratio to the fifth, bits 39:8
    cicg_row_t    rows [7] = '{
        '{'{1'b0, 4'h0, 6'h00, 1'b1}, 3'h0, 15'h0123, 32'h0246_0000},
        '{'{1'b0, 4'h2, 6'h00, 1'b0}, 3'h0, 15'h0100, 32'h0000_0004},
        '{'{1'b0, 4'h3, 6'h00, 1'b0}, 3'h2, 15'h7ff0, 32'hffff_fffe},
        '{'{1'b0, 4'he, 6'h00, 1'b0}, 3'h3, 15'h0001, 32'h0000_0080},
        '{'{1'b0, 4'h0, 6'h01, 1'b0}, 3'h0, 15'h0100, 32'h0000_0020},
        '{'{1'b0, 4'h0, 6'h03, 1'b0}, 3'h1, 15'h0100, 32'h0000_0800},
        '{'{1'b0, 4'h0, 6'h1f, 1'b0}, 3'h0, 15'h3f00, 32'h7e00_0000}};
    // Free-running 40 MHz clock
    always #12.5 mclk = ~mclk;
    // Strobe tally for pairing checks
    always @(posedge mclk) if (out_strobe === 1'b1) n_strobe++;
    cicg_decimator cicg_decimator_i (
        .mclk(mclk), .rst(rst), .cfg_word(cfg_word), .mix_prod(mix_prod),
        .sample_valid_n(sample_valid_n), .pin_gain_offset(pin_gain_offset),
        .multi_chip_sync_pulse(multi_chip_sync_pulse), .out_sample(out_sample),
        .out_strobe(out_strobe), .dec_count(dec_count));
    cicg_mixer_model cicg_mixer_model_i (
        .mclk(mclk), .rst(rst), .val(val), .num(num), .go(go), .mix_prod(mix_prod),
        .sample_valid_n(sample_valid_n), .busy(busy));
    function automatic logic [31:0] word_of(input cicg_cfg_t c);
        return {12'h0, c.ext_sync_en, 2'h0, c.shift_word, c.dec_preload, c.bypass, 6'h0};
    endfunction : word_of
    task automatic results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
        n_checks++;
        if (got !== want) begin
            miscompares++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : check
    // Send n samples, wait boundedly for the model, then let the pipeline drain
    task automatic feed(input int n);
        int k;
        k = 0;
        num <= 10'(n);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        while (busy !== 1'b0 && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 3000) begin
            miscompares++;
            $display("Error at %0t: sample source hung", $time);
            results();
        end
        repeat (12) @(posedge mclk);
    endtask : feed
    task automatic sync_pulse;
        multi_chip_sync_pulse <= 1'b1;
        repeat (2) @(posedge mclk);
        multi_chip_sync_pulse <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : sync_pulse
    // Main sequence: sync cases first while the counter is known, then the table
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        cfg_word <= word_of('{1'b0, 4'h0, 6'h03, 1'b0});
        @(posedge mclk);
        sync_pulse();
        check({26'h0, dec_count}, 32'h0, "sync while disabled");
        cfg_word <= word_of('{1'b1, 4'h0, 6'h03, 1'b0});
        sync_pulse();
        check({26'h0, dec_count}, 32'h3, "sync reload");
        n_strobe = 0;
        feed(8);
        check(32'(n_strobe), 32'h2, "outputs per ratio");
        $display("test sync done");
        for (int i = 0; i < 7; i++) begin
            cfg_word <= word_of(rows[i].cfg);
            pin_gain_offset <= rows[i].gain;
            val <= rows[i].v;
            repeat (4) @(posedge mclk);
            n_strobe = 0;
            feed((rows[i].cfg.dec_preload + 1) * 12);
            check(out_sample.data, rows[i].exp, "steady output");
            if (rows[i].cfg.bypass) check(32'(n_strobe), 32'd12, "bypass strobes");
            $display("test row %0d done", i);
        end
        feed(1);
        check({26'h0, dec_count}, 32'h1f, "counter before reset");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check(out_sample.data, 32'h0, "output after reset");
        check({25'h0, out_strobe, dec_count}, 32'h0, "state after reset");
        $display("test reset done");
        results();
    end
endmodule : cicg_decimator_tb
`default_nettype wire
